// ==== design/nv_seq_pkg.sv ====
// package: sram bus pin groups, sequence addresses and timing for the store/recall host
package nv_seq_pkg;

    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int SEQ_LEN = 6;

    // unlock sequence, steps 0..4 shared, step 5 picks the command
    localparam logic [12:0] SEQ_A0 = 13'h0000;
    localparam logic [12:0] SEQ_A1 = 13'h1555;
    localparam logic [12:0] SEQ_A2 = 13'h0aaa;
    localparam logic [12:0] SEQ_A3 = 13'h1fff;
    localparam logic [12:0] SEQ_A4 = 13'h10f0;
    localparam logic [12:0] SEQ_STORE = 13'h0f0f;
    localparam logic [12:0] SEQ_RECALL = 13'h0f0e;

    // timing at 200 MHz
    localparam int CLK_MHZ = 200;
    localparam int T_RC_NS = 45;
    localparam int T_STORE_MS = 10;
    localparam int T_RECALL_US = 550;
    localparam int RC_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000;
    localparam int STORE_CYC = T_STORE_MS * 1000 * CLK_MHZ;
    localparam int RECALL_CYC = T_RECALL_US * CLK_MHZ;
    localparam int CNT_W = 24;

    // pins toward the memory
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [12:0] word_address;
        logic [7:0] dq_out;
        logic dq_oe;
    } sram_pins_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_STROBE = 5'b00100,
        ST_GAP = 5'b01000,
        ST_WAIT = 5'b10000
    } host_state_e;

    localparam logic [3:0] STEP_RST = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

endpackage

// ==== design/nv_seq_rom.sv ====
// module: address of each step of the unlock sequence
`timescale 1ns/100ps
module nv_seq_rom
    import nv_seq_pkg::*;
(
    input wire logic [3:0] step,
    input wire logic recall,
    output logic [12:0] addr
);
    always_comb begin
        unique case (step)
            4'h0: addr = SEQ_A0;
            4'h1: addr = SEQ_A1;
            4'h2: addr = SEQ_A2;
            4'h3: addr = SEQ_A3;
            4'h4: addr = SEQ_A4;
            default: addr = recall ? SEQ_RECALL : SEQ_STORE;
        endcase
    end
endmodule // nv_seq_rom

// ==== design/nv_store_recall_host.sv ====
// module: host that issues software store and recall sequences to the memory
// How it works
// - store: six ce reads ending 0x0f0f
// - recall: same five reads, sixth 0x0f0e
// - write enable stays high every step
// - firmware checks own signature, not presets
// - boot firmware rewrites memory contents
`timescale 1ns/100ps
module nv_store_recall_host
    import nv_seq_pkg::*;
#(
    parameter int STORE_WAIT = STORE_CYC,
    parameter int RECALL_WAIT = RECALL_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic recall,
    output logic busy,
    output logic done,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic [12:0] word_address,
    output logic [7:0] dq_out,
    output logic dq_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        host_state_e st;
        logic [3:0] step;
        logic op_recall;
        logic [CNT_W-1:0] cnt;
        logic done;
        logic busy;
        sram_pins_s pins;
    } host_s;

    host_s q_r;
    host_s q_nxt;
    logic [12:0] step_addr;

    nv_seq_rom u_rom (
        .step(q_r.step),
        .recall(q_r.op_recall),
        .addr(step_addr)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        q_nxt.done = 1'b0;
        // pins never write: we_n high, data not driven
        q_nxt.pins.we_n = 1'b1;
        q_nxt.pins.dq_oe = 1'b0;
        // rewriting the array is left to firmware over the normal bus
        q_nxt.pins.dq_out = 8'h00;
        unique case (q_r.st)
            ST_IDLE: begin
                q_nxt.pins.ce_n = 1'b1;
                // never reads data back, so assumes nothing about contents
                q_nxt.pins.oe_n = 1'b1;
                if (start) begin
                    q_nxt.op_recall = recall;
                    q_nxt.step = STEP_RST;
                    q_nxt.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // address settles with ce high
                q_nxt.pins.word_address = step_addr;
                q_nxt.cnt = CNT_W'(RC_CYC);
                q_nxt.st = ST_STROBE;
            end
            ST_STROBE: begin
                // ce controlled read, oe left high
                q_nxt.pins.ce_n = 1'b0;
                if (q_r.cnt == CNT_RST) begin
                    q_nxt.pins.ce_n = 1'b1;
                    q_nxt.cnt = CNT_W'(RC_CYC);
                    q_nxt.st = ST_GAP;
                end else begin
                    q_nxt.cnt = q_r.cnt - 1'b1;
                end
            end
            ST_GAP: begin
                q_nxt.pins.ce_n = 1'b1;
                if (q_r.cnt == CNT_RST) begin
                    if (q_r.step == 4'(SEQ_LEN - 1)) begin
                        // no access until the nv cycle ends
                        q_nxt.cnt = q_r.op_recall ? CNT_W'(RECALL_WAIT)
                                                  : CNT_W'(STORE_WAIT);
                        q_nxt.st = ST_WAIT;
                    end else begin
                        q_nxt.step = q_r.step + 4'h1;
                        q_nxt.st = ST_SETUP;
                    end
                end else begin
                    q_nxt.cnt = q_r.cnt - 1'b1;
                end
            end
            ST_WAIT: begin
                q_nxt.pins.ce_n = 1'b1;
                if (q_r.cnt == CNT_RST) begin
                    q_nxt.done = 1'b1;
                    q_nxt.step = STEP_RST;
                    q_nxt.st = ST_IDLE;
                end else begin
                    q_nxt.cnt = q_r.cnt - 1'b1;
                end
            end
            default: q_nxt.st = ST_IDLE;
        endcase
        q_nxt.busy = (q_nxt.st != ST_IDLE);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_r.st <= ST_IDLE;
            q_r.step <= STEP_RST;
            q_r.op_recall <= 1'b0;
            q_r.cnt <= CNT_RST;
            q_r.done <= 1'b0;
            q_r.busy <= 1'b0;
            q_r.pins.ce_n <= 1'b1;
            q_r.pins.we_n <= 1'b1;
            q_r.pins.oe_n <= 1'b1;
            q_r.pins.word_address <= SEQ_A0;
            q_r.pins.dq_out <= 8'h00;
            q_r.pins.dq_oe <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign busy = q_r.busy;
    assign done = q_r.done;
    assign ce_n = q_r.pins.ce_n;
    assign we_n = q_r.pins.we_n;
    assign oe_n = q_r.pins.oe_n;
    assign word_address = q_r.pins.word_address;
    assign dq_out = q_r.pins.dq_out;
    assign dq_oe = q_r.pins.dq_oe;
endmodule // nv_store_recall_host

// ==== testbench/nv_seq_sva.sv ====
// checker: host-side timing of the unlock sequence
`timescale 1ns/100ps
module nv_seq_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic busy,
    input wire logic done,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    input wire logic [12:0] word_address
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence ce_low_s;
        !ce_n [*8];
    endsequence
    a_we_high: assert property (we_n) else $error("write enable low");
    a_bus_quiet: assert property (!dq_oe && dq_out == 8'h00) else $error("data driven");
    a_oe_high: assert property (oe_n) else $error("output enable low");
    a_start_busy: assert property (start && !busy |=> busy) else $error("start lost");
    a_addr_hold: assert property (!ce_n |-> $stable(word_address)) else $error("addr moved");
    a_ce_width: assert property ($fell(ce_n) |-> ce_low_s) else $error("ce short");
    a_done_end: assert property (done && !start |=> !busy) else $error("busy after done");
    a_idle_ce: assert property (!busy |-> ce_n) else $error("ce low idle");
endmodule // nv_seq_sva
bind nv_store_recall_host nv_seq_sva chk_u (.clk(clk), .rst(rst), .start(start), .busy(busy),
    .done(done), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq_out(dq_out), .dq_oe(dq_oe),
    .word_address(word_address));

// ==== testbench/nv_mem_model.sv ====
// model: memory decoding ce-clocked unlock reads into nv commands
`timescale 1ns/100ps
module nv_mem_model
    import nv_seq_pkg::*;
#(
    parameter int NV_NS = 60
) (
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic [12:0] word_address,
    output logic [1:0] cmd
);
    logic [12:0] seq_r [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    int step = 0;
    initial cmd = 2'h0;
    always @(negedge ce_n) begin
        if (we_n !== 1'b1) begin
            step = 0;
        end else if (step == 5) begin
            cmd = (word_address === SEQ_STORE) ? 2'h1 :
                (word_address === SEQ_RECALL) ? 2'h2 : 2'h0;
            step = 0;
            #NV_NS;
            cmd = 2'h0;
        end else begin
            step = (word_address === seq_r[step]) ? step + 1 :
                int'(word_address === SEQ_A0);
        end
    end
endmodule // nv_mem_model

// ==== testbench/testbench.sv ====
// testbench: random store and recall requests against the memory model
`timescale 1ns/100ps
module testbench;
    logic clk = 0, rst = 1, start = 0, recall = 0, busy, done, ce_n, we_n;
    logic [12:0] word_address;
    logic [1:0] cmd;
    logic [1:0] exp_q [$];
    logic [15:0] lfsr_r = 16'hb82e;
    int error_cnt = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    nv_store_recall_host #(.STORE_WAIT(20), .RECALL_WAIT(20)) dut_u (.clk(clk), .rst(rst),
        .start(start), .recall(recall), .busy(busy), .done(done), .ce_n(ce_n), .we_n(we_n),
        .oe_n(), .word_address(word_address), .dq_out(), .dq_oe());
    nv_mem_model mem_u (.ce_n(ce_n), .we_n(we_n), .word_address(word_address), .cmd(cmd));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task check(input logic [1:0] seen, input logic [1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %0d expected %0d", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(cmd) if (cmd !== 2'h0) check(cmd, exp_q.size() ? exp_q.pop_front() : 2'h3);
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        // reset partway through a store: the memory must see no command
        @(posedge clk);
        start <= 1;
        @(posedge clk);
        start <= 0;
        repeat (50) @(posedge clk);
        @(negedge clk);
        check({1'b0, busy}, 2'h1);
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(negedge clk);
        check({busy, ce_n}, 2'h1);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            lfsr_r = lfsr(lfsr_r);
            start <= 1;
            recall <= lfsr_r[0];
            exp_q.push_back(lfsr_r[0] ? 2'h2 : 2'h1);
            @(posedge clk);
            // odd passes retry start while busy; every pass flips the command while busy
            start <= i[0];
            @(posedge clk);
            start <= 0;
            recall <= ~lfsr_r[0];
            for (int k = 0; k < 400 && done !== 1'b1; k++) @(negedge clk);
            check({1'b0, done}, 2'h1);
        end
        repeat (30) @(posedge clk);
        check({1'b0, exp_q.size() != 0}, 2'h0);
        test_done;
    end
    initial begin
        #20000;
        error_cnt++;
        test_done;
    end
endmodule // testbench
